// ==== core/bpcc_top.sv ====
/*
 Common control and status register slice on an AHB-Lite slave port:
 error channel select, cell mode enables, phased software reset,
 transmit configuration done strobe and per-channel alarm summary.
 Assumes error and alarm inputs are synchronous to hclk, and that the
 master issues only single whole-word transfers.
*/
// Implementation choice: the AHB-Lite slave port.
// Functional notes
// [RULE1] Select code 010/011/110/111 routes channel AC/AD/BC/BD errors to both counters.
// [RULE2] Group A cell enable set drives cell mode on channels AC and AD together.
// [RULE3] Group B cell enable set drives cell mode on channels BC and BD together.
// [RULE4] A two-bit phase field picks one of four delays for the software reset.
// [RULE5] Software reset resets the core logic while the registers keep their values.
// [RULE6] Software reset leaves the serializer/deserializer register state untouched.
// [RULE7] Transmit config done acts only on a rising edge, so software writes 0 then 1.
// [RULE8] Each channel alarm summary bit is the OR of that channel's alarm bits.
// [RULE9] Any alarm summary bit at one raises the fabric-side alarm indication.
// [RULE10] The selected channel's parity counters count each error and clear on read.
// [RULE11] Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module bpcc_top
    import bpcc_pkg::*;
#(
    parameter int ALARM_W = 8
) (
    // Clock and reset
    input  wire logic                           hclk,
    input  wire logic                           hresetn,
    // AHB-Lite slave
    input  wire bpcc_ahb_in_t                   ahb_i,
    output bpcc_ahb_out_t                       ahb_o,
    // Per-channel error strobes, order AC AD BC BD
    input  wire logic [N_CH-1:0]                sect_err_i,
    input  wire logic [N_CH-1:0]                cell_err_i,
    // Per-channel alarm status bits
    input  wire logic [N_CH-1:0][ALARM_W-1:0]   alarm_bits_i,
    // Core controls
    output logic                                cell_mode_group_a,
    output logic                                cell_mode_group_b,
    output logic                                core_soft_reset,
    output logic                                tx_cfg_done_pulse,
    output logic                                alarm_irq
);

    // Refused at elaboration, not at run time
    if (ALARM_W < 1) begin : g_bad_alarm_w
        $error("bpcc_top: ALARM_W must be at least 1");
    end

    bpcc_state_t      s_reg;
    bpcc_state_t      s_next;
    logic             addr_ok;
    logic             rd_take;
    logic [IDX_W-1:0] rd_idx;
    logic             sect_inc;
    logic             cell_inc;
    logic             sect_clr;
    logic             cell_clr;
    logic [CNT_W-1:0] sect_count;
    logic [CNT_W-1:0] cell_count;
    logic             phased_reset;
    logic [7:0]       alarm_sum;
    logic [2:0]       sel;

    assign sel = s_reg.sel_cell[SEL_MSB:SEL_LSB];

    // Channel routing to shared counters; other codes count nothing
    always_comb begin
        sect_inc = 1'b0;
        cell_inc = 1'b0;
        unique case (sel)
            SEL_AC: begin
                sect_inc = sect_err_i[CH_AC]; // RULE1
                cell_inc = cell_err_i[CH_AC];
            end
            SEL_AD: begin
                sect_inc = sect_err_i[CH_AD]; // RULE1
                cell_inc = cell_err_i[CH_AD];
            end
            SEL_BC: begin
                sect_inc = sect_err_i[CH_BC]; // RULE1
                cell_inc = cell_err_i[CH_BC];
            end
            SEL_BD: begin
                sect_inc = sect_err_i[CH_BD]; // RULE1
                cell_inc = cell_err_i[CH_BD];
            end
            default: begin
                sect_inc = 1'b0;
                cell_inc = 1'b0;
            end
        endcase
    end

    // Alarm summary per channel
    always_comb begin
        alarm_sum = 8'h00;
        alarm_sum[ALM_BD_BIT] = |alarm_bits_i[CH_BD]; // RULE8
        alarm_sum[ALM_BC_BIT] = |alarm_bits_i[CH_BC]; // RULE8
        alarm_sum[ALM_AD_BIT] = |alarm_bits_i[CH_AD]; // RULE8
        alarm_sum[ALM_AC_BIT] = |alarm_bits_i[CH_AC]; // RULE8
    end

    // Address phase decode; only the low index bits are mapped
    assign addr_ok = (ahb_i.haddr[31:IDX_W+IDX_LSB] == '0);
    assign rd_idx  = ahb_i.haddr[IDX_W+IDX_LSB-1:IDX_LSB];
    assign rd_take = ahb_i.hsel && ahb_i.hready && !ahb_i.hwrite
                     && (ahb_i.htrans == HTRANS_NONSEQ || ahb_i.htrans == HTRANS_SEQ);
    assign sect_clr = rd_take && addr_ok && rd_idx == IDX_SECT; // RULE10
    assign cell_clr = rd_take && addr_ok && rd_idx == IDX_CELL; // RULE10

    always_comb begin
        s_next = s_reg;
        s_next.ready = 1'b1;
        // Write data phase; reserved bits are masked off
        if (s_reg.wr_pend) begin
            unique case (s_reg.wr_idx)
                IDX_SEL: s_next.sel_cell = ahb_i.hwdata[7:0] & MASK_SEL; // RULE11
                IDX_RST: s_next.rst_ctl  = ahb_i.hwdata[7:0] & MASK_RST; // RULE11
                IDX_TX:  s_next.tx_ctl   = ahb_i.hwdata[7:0] & MASK_TX; // RULE11
                default: s_next.wr_pend  = 1'b0;
            endcase
        end
        s_next.wr_pend = ahb_i.hsel && ahb_i.hready && ahb_i.hwrite && addr_ok
                         && (ahb_i.htrans == HTRANS_NONSEQ || ahb_i.htrans == HTRANS_SEQ);
        s_next.wr_idx  = rd_idx;
        // Edge detect, so a held one does not retrigger
        s_next.tx_prev  = s_reg.tx_ctl[TX_DONE_BIT];
        s_next.tx_pulse = s_reg.tx_ctl[TX_DONE_BIT] && !s_reg.tx_prev; // RULE7
        s_next.alarm = alarm_sum;
        s_next.irq   = |alarm_sum; // RULE9
        // Read data from post-write values, avoiding a stale read after write
        s_next.rdata = 32'h0000_0000;
        if (rd_take && addr_ok) begin
            unique case (rd_idx)
                IDX_ALARM: s_next.rdata[7:0] = s_reg.alarm;
                IDX_SEL:   s_next.rdata[7:0] = s_next.sel_cell;
                IDX_RST:   s_next.rdata[7:0] = s_next.rst_ctl;
                IDX_TX:    s_next.rdata[7:0] = s_next.tx_ctl;
                IDX_SECT:  s_next.rdata[7:0] = sect_count;
                IDX_CELL:  s_next.rdata[7:0] = cell_count;
                default:   s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg.sel_cell <= RST_VAL;
            s_reg.rst_ctl  <= RST_VAL;
            s_reg.tx_ctl   <= RST_VAL;
            s_reg.alarm    <= RST_VAL;
            s_reg.tx_prev  <= 1'b0;
            s_reg.tx_pulse <= 1'b0;
            s_reg.irq      <= 1'b0;
            s_reg.wr_pend  <= 1'b0;
            s_reg.wr_idx   <= '0;
            s_reg.rdata    <= 32'h0000_0000;
            s_reg.ready    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    bpcc_err_counter #(
        .WIDTH (CNT_W)
    ) u_sect_cnt (
        .clk   (hclk),
        .rst_n (hresetn),
        .inc   (sect_inc),
        .clr   (sect_clr),
        .count (sect_count)
    );

    bpcc_err_counter #(
        .WIDTH (CNT_W)
    ) u_cell_cnt (
        .clk   (hclk),
        .rst_n (hresetn),
        .inc   (cell_inc),
        .clr   (cell_clr),
        .count (cell_count)
    );

    // Core reset only; registers here and the serdes stay as they are
    bpcc_reset_phaser #(
        .PHASES (N_PHASE)
    ) u_phaser (
        .clk     (hclk),
        .rst_n   (hresetn),
        .req     (s_reg.rst_ctl[SOFT_RST_BIT]), // RULE5 RULE6
        .phase   (s_reg.rst_ctl[PHASE_MSB:PHASE_LSB]),
        .rst_out (phased_reset)
    );

    assign ahb_o.hreadyout = s_reg.ready;
    assign ahb_o.hresp     = HRESP_OKAY;
    assign ahb_o.hrdata    = s_reg.rdata;
    assign cell_mode_group_a = s_reg.sel_cell[CELL_A_BIT]; // RULE2
    assign cell_mode_group_b = s_reg.sel_cell[CELL_B_BIT]; // RULE3
    assign core_soft_reset   = phased_reset; // RULE5
    assign tx_cfg_done_pulse = s_reg.tx_pulse;
    assign alarm_irq         = s_reg.irq;

    sequence s_tx_rise;
        $rose(s_reg.tx_ctl[TX_DONE_BIT]);
    endsequence

    chk_tx_rise_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        s_tx_rise |=> tx_cfg_done_pulse ##1 !tx_cfg_done_pulse)
        else $error("tx done pulse wrong on rising edge");
    chk_tx_no_level: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
        s_reg.tx_ctl[TX_DONE_BIT] [*2] |=> !tx_cfg_done_pulse)
        else $error("tx done pulse on held level");
    chk_alarm_or: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        (|alarm_bits_i[CH_AC]) |=> s_reg.alarm[ALM_AC_BIT])
        else $error("alarm AC summary missing");
    chk_alarm_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        (alarm_bits_i[CH_BD] == '0) |=> !s_reg.alarm[ALM_BD_BIT])
        else $error("alarm BD summary stuck");
    chk_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        $past(hresetn) |-> alarm_irq == $past(alarm_bits_i != '0))
        else $error("alarm indication mismatch");
    chk_route_bd: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        sel == SEL_BD |-> sect_inc == sect_err_i[CH_BD] && cell_inc == cell_err_i[CH_BD])
        else $error("channel BD not routed");
    chk_route_none: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        sel[1] == 1'b0 |-> !sect_inc && !cell_inc)
        else $error("unselected channel counted");
    chk_cell_mode_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
        s_reg.wr_pend && s_reg.wr_idx == IDX_SEL
        |=> cell_mode_group_a == $past(ahb_i.hwdata[CELL_A_BIT]))
        else $error("group A cell mode not written");
    chk_cell_mode_b: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
        s_reg.wr_pend && s_reg.wr_idx == IDX_SEL
        |=> cell_mode_group_b == $past(ahb_i.hwdata[CELL_B_BIT]))
        else $error("group B cell mode not written");
    chk_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        ahb_o.hrdata[31:8] == 24'h000000 && (s_reg.rst_ctl & ~MASK_RST) == 8'h00)
        else $error("reserved bits not zero");
    chk_regs_kept: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
        core_soft_reset && !s_reg.wr_pend |=> s_reg.rst_ctl == $past(s_reg.rst_ctl))
        else $error("register lost during soft reset");

endmodule
`default_nettype wire

// ==== core/bpcc_pkg.sv ====
/*
 Shared constants and carrier types for the common control register slice.
 Assumes a single AHB-Lite master and one 25 MHz clock.
*/
package bpcc_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [17:0] IDX_ALARM = 18'h30408;
    localparam logic [17:0] IDX_SEL   = 18'h30A05;
    localparam logic [17:0] IDX_RST   = 18'h30A06;
    localparam logic [17:0] IDX_TX    = 18'h30A07;
    localparam logic [17:0] IDX_SECT  = 18'h30A09;
    localparam logic [17:0] IDX_CELL  = 18'h30A0A;
    localparam int          IDX_W     = 18;
    localparam int          IDX_LSB   = 2;

    // Writable bit masks; other bits are reserved
    localparam logic [7:0] MASK_SEL = 8'h57;
    localparam logic [7:0] MASK_RST = 8'hE0;
    localparam logic [7:0] MASK_TX  = 8'h80;
    localparam logic [7:0] RST_VAL  = 8'h00;

    // Field positions
    localparam int SEL_LSB     = 0;
    localparam int SEL_MSB     = 2;
    localparam int CELL_A_BIT  = 4;
    localparam int CELL_B_BIT  = 6;
    localparam int PHASE_LSB   = 5;
    localparam int PHASE_MSB   = 6;
    localparam int SOFT_RST_BIT = 7;
    localparam int TX_DONE_BIT = 7;
    localparam int ALM_BD_BIT  = 0;
    localparam int ALM_BC_BIT  = 1;
    localparam int ALM_AD_BIT  = 4;
    localparam int ALM_AC_BIT  = 5;

    // Channel order on per-channel input vectors
    localparam int CH_AC = 0;
    localparam int CH_AD = 1;
    localparam int CH_BC = 2;
    localparam int CH_BD = 3;
    localparam int N_CH  = 4;

    // Error channel select codes
    localparam logic [2:0] SEL_AC = 3'h2;
    localparam logic [2:0] SEL_AD = 3'h3;
    localparam logic [2:0] SEL_BC = 3'h6;
    localparam logic [2:0] SEL_BD = 3'h7;

    localparam int         CNT_W      = 8;
    localparam int         N_PHASE    = 4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } bpcc_ahb_in_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } bpcc_ahb_out_t;

    typedef struct packed {
        logic [7:0]       sel_cell;
        logic [7:0]       rst_ctl;
        logic [7:0]       tx_ctl;
        logic [7:0]       alarm;
        logic             tx_prev;
        logic             tx_pulse;
        logic             irq;
        logic             wr_pend;
        logic [IDX_W-1:0] wr_idx;
        logic [31:0]      rdata;
        logic             ready;
    } bpcc_state_t;

endpackage

// ==== core/bpcc_err_counter.sv ====
/*
 Saturating event counter with clear on read.
 Assumes inc and clr are single-cycle synchronous strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module bpcc_err_counter
    import bpcc_pkg::*;
#(
    parameter int WIDTH = CNT_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Strobes
    input  wire logic             inc,
    input  wire logic             clr,
    // Count
    output logic [WIDTH-1:0]      count
);

    // Read data path is one word, so wider counts cannot be served
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("bpcc_err_counter: WIDTH out of range");
    end

    localparam logic [WIDTH-1:0] CNT_MAX  = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] CNT_ZERO = '0;
    localparam logic [WIDTH-1:0] CNT_ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // An error in the read cycle is kept: the clear restarts the count at one
    always_comb begin
        count_next = count_reg;
        if (clr) begin
            count_next = inc ? CNT_ONE : CNT_ZERO; // RULE10
        end else if (inc && count_reg != CNT_MAX) begin
            count_next = count_reg + CNT_ONE; // RULE10
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

    chk_count_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        inc && !clr && count_reg != CNT_MAX |=> count_reg == $past(count_reg) + CNT_ONE)
        else $error("counter did not step");
    chk_read_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        clr |=> count_reg == ($past(inc) ? CNT_ONE : CNT_ZERO))
        else $error("counter not cleared by read");

endmodule
`default_nettype wire

// ==== core/bpcc_reset_phaser.sv ====
/*
 Delays the software reset level by one of four selectable phases.
 Assumes the bus clock is the synchronizing clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bpcc_reset_phaser
    import bpcc_pkg::*;
#(
    parameter int PHASES = N_PHASE
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Request and phase select
    input  wire logic                      req,
    input  wire logic [$clog2(PHASES)-1:0] phase,
    // Delayed reset level
    output logic                           rst_out
);

    // Phase index must not reach past the tap line, so a power of two only
    if (PHASES < 2 || (PHASES & (PHASES - 1)) != 0) begin : g_bad_phases
        $error("bpcc_reset_phaser: PHASES must be a power of two, at least 2");
    end

    logic [PHASES-1:0] tap_reg;
    logic [PHASES-1:0] tap_next;
    logic              out_reg;
    logic              out_next;

    always_comb begin
        tap_next = {tap_reg[PHASES-2:0], req};
        out_next = tap_reg[phase]; // RULE4
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            tap_reg <= tap_next;
            out_reg <= out_next;
        end
    end

    assign rst_out = out_reg;

    sequence s_rise_ph0;
        $rose(req) ##1 (phase == 2'h0);
    endsequence
    sequence s_rise_ph3;
        $rose(req) ##4 (phase == 2'h3);
    endsequence

    chk_phase_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        s_rise_ph0 |-> ##1 rst_out)
        else $error("reset not applied at phase 0");
    chk_phase_three: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        s_rise_ph3 |-> ##1 rst_out)
        else $error("reset not applied at phase 3");

endmodule
`default_nettype wire

// ==== verification/bpcc_tb_top.sv ====
/*
 Self-checking testbench for the common control register slice.
 Assumes the design answers every AHB-Lite transfer with hreadyout and
 that all error and alarm inputs are synchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module bpcc_tb_top
    import bpcc_pkg::*;
;
    localparam int AW = 8;

    logic                         hclk;
    logic                         hresetn;
    bpcc_ahb_in_t                 bus;
    bpcc_ahb_in_t                 ahb_i;
    bpcc_ahb_out_t                ahb_o;
    logic [N_CH-1:0]              sect_err_i;
    logic [N_CH-1:0]              cell_err_i;
    logic [N_CH-1:0][AW-1:0]      alarm_bits_i;
    logic [N_CH-1:0][AW-1:0]      av;
    logic                         cell_mode_group_a;
    logic                         cell_mode_group_b;
    logic                         core_soft_reset;
    logic                         tx_cfg_done_pulse;
    logic                         alarm_irq;
    int                           mismatches;
    int                           compares;
    int                           n;
    int                           cnt;
    int                           lat [N_PHASE];
    logic [7:0]                   cm_val [3] = '{8'h10, 8'h40, 8'h00};
    logic [2:0]                   codes [5]  = '{SEL_AC, SEL_AD, SEL_BC, SEL_BD, 3'h0};
    int                           alm_pos [N_CH] = '{ALM_AC_BIT, ALM_AD_BIT, ALM_BC_BIT,
                                                     ALM_BD_BIT};
    logic [IDX_W-1:0]             idx_all [6] = '{IDX_ALARM, IDX_SEL, IDX_RST, IDX_TX,
                                                  IDX_SECT, IDX_CELL};

    // Single slave, so its hreadyout is the bus hready
    always_comb begin
        ahb_i        = bus;
        ahb_i.hready = ahb_o.hreadyout;
    end

    bpcc_top #(
        .ALARM_W (AW)
    ) u_dut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .ahb_i             (ahb_i),
        .ahb_o             (ahb_o),
        .sect_err_i        (sect_err_i),
        .cell_err_i        (cell_err_i),
        .alarm_bits_i      (alarm_bits_i),
        .cell_mode_group_a (cell_mode_group_a),
        .cell_mode_group_b (cell_mode_group_b),
        .core_soft_reset   (core_soft_reset),
        .tx_cfg_done_pulse (tx_cfg_done_pulse),
        .alarm_irq         (alarm_irq)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic end_sim();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ba(input logic [IDX_W-1:0] idx);
        return {12'h000, idx, 2'b00};
    endfunction

    // Bounded wait so a stuck slave ends the run instead of hanging it
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (ahb_o.hreadyout !== 1'b1 && k < 16);
        if (ahb_o.hreadyout !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic wr_en, input logic [31:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata);
        bus.hsel   <= 1'b1;
        bus.haddr  <= addr;
        bus.htrans <= HTRANS_NONSEQ;
        bus.hwrite <= wr_en;
        bus.hsize  <= 3'h2;
        wait_ready();
        bus.hsel   <= 1'b0;
        bus.htrans <= 2'h0;
        bus.hwdata <= wdata;
        wait_ready();
        rdata = ahb_o.hrdata;
        chk_out(ahb_o.hresp, HRESP_OKAY);
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        xfer(1'b1, addr, data, dummy);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        xfer(1'b0, addr, 32'h0000_0000, got);
        chk_reg(got, exp);
    endtask

    // Gap cycle after each strobe keeps one assignment per time step
    task automatic strobe(input logic [N_CH-1:0] s, input logic [N_CH-1:0] c);
        sect_err_i <= s;
        cell_err_i <= c;
        @(posedge hclk);
        sect_err_i <= '0;
        cell_err_i <= '0;
        @(posedge hclk);
    endtask

    initial begin
        hresetn      = 1'b0;
        bus          = '0;
        sect_err_i   = '0;
        cell_err_i   = '0;
        alarm_bits_i = '0;
        mismatches   = 0;
        compares     = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (idx_all[i]) rd_chk(ba(idx_all[i]), 32'h0000_0000);
        wr(ba(IDX_SEL), 32'hFFFF_FFFF);
        rd_chk(ba(IDX_SEL), 32'h0000_0057);
        for (int i = 0; i < 3; i++) begin
            wr(ba(IDX_SEL), {24'h000000, cm_val[i]});
            @(posedge hclk);
            chk_out(cell_mode_group_a, cm_val[i][CELL_A_BIT]);
            chk_out(cell_mode_group_b, cm_val[i][CELL_B_BIT]);
        end
        wr(ba(IDX_ALARM), 32'hFFFF_FFFF);
        rd_chk(ba(IDX_ALARM), 32'h0000_0000);
        wr(ba(IDX_SEL), 32'h0000_0057);
        wr(32'h1000_0000 | ba(IDX_SEL), 32'h0000_0000);
        rd_chk(ba(IDX_SEL), 32'h0000_0057);
        rd_chk(32'h1000_0000 | ba(IDX_SEL), 32'h0000_0000);
        rd_chk(32'h0000_1000, 32'h0000_0000);
        // Channel j sees j+1 section errors and 4-j cell errors
        for (int i = 0; i < 5; i++) begin
            wr(ba(IDX_SEL), {29'h0, codes[i]});
            for (int p = 0; p < N_CH; p++) begin
                strobe(4'(4'hF << p), 4'(4'hF >> (3 - p)));
            end
            rd_chk(ba(IDX_SECT), (i < 4) ? 32'(i + 1) : 32'h0000_0000);
            rd_chk(ba(IDX_SECT), 32'h0000_0000);
            rd_chk(ba(IDX_CELL), (i < 4) ? 32'(4 - i) : 32'h0000_0000);
            rd_chk(ba(IDX_CELL), 32'h0000_0000);
        end
        // Absolute latency is a design choice, so only phase steps are checked
        wr(ba(IDX_SEL), 32'h0000_0057);
        for (int ph = 0; ph < N_PHASE; ph++) begin
            wr(ba(IDX_RST), 32'h0000_0080 | 32'(ph << PHASE_LSB));
            n = 0;
            while (core_soft_reset !== 1'b1 && n < 12) begin
                @(posedge hclk);
                n++;
            end
            lat[ph] = n;
            chk_out(core_soft_reset, 1'b1);
            chk_reg(32'(lat[ph] - lat[0]), 32'(ph));
            rd_chk(ba(IDX_RST), 32'h0000_0080 | 32'(ph << PHASE_LSB));
            rd_chk(ba(IDX_SEL), 32'h0000_0057);
            wr(ba(IDX_RST), 32'h0000_0000);
            repeat (8) @(posedge hclk);
            chk_out(core_soft_reset, 1'b0);
        end
        // Set, set again, clear, set: only the rising writes pulse
        for (int k = 0; k < 4; k++) begin
            wr(ba(IDX_TX), (k == 2) ? 32'h0000_0000 : 32'hFFFF_FFFF);
            cnt = 0;
            repeat (6) begin
                @(posedge hclk);
                cnt += int'(tx_cfg_done_pulse === 1'b1);
            end
            chk_reg(32'(cnt), (k == 1 || k == 2) ? 32'h0 : 32'h1);
        end
        rd_chk(ba(IDX_TX), 32'h0000_0080);
        for (int c = 0; c < N_CH; c++) begin
            av = '0;
            av[c][AW - 1 - c] = 1'b1;
            alarm_bits_i <= av;
            repeat (4) @(posedge hclk);
            chk_out(alarm_irq, 1'b1);
            rd_chk(ba(IDX_ALARM), 32'(1) << alm_pos[c]);
        end
        alarm_bits_i <= '0;
        repeat (4) @(posedge hclk);
        chk_out(alarm_irq, 1'b0);
        rd_chk(ba(IDX_ALARM), 32'h0000_0000);
        end_sim();
    end

endmodule
`default_nettype wire
